//--- design/tcc_top.sv
// triple comparator control and status logic with avalon-mm slave
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_top
  import tcc_pkg::*;
#(
  parameter int NUM_CH = `TCC_NUM_CH
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // avalon-mm slave
  input  wire logic [7:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // analog front end
  input  wire logic [2:0]          cmp_raw_i,
  output tcc_afe_t  [2:0]          afe_o,
  // remappable pins
  input  wire logic [2:0]          pin_dir_i,
  output logic      [2:0]          pin_sel_o,
  output logic      [2:0]          pin_out_o,
  output logic      [2:0]          pin_oe_o,
  // event flags
  output logic      [2:0]          event_flag_o
);

  generate
    if (NUM_CH != `TCC_NUM_CH) begin : g_chk
      $error("tcc_top serves exactly three channels");
    end
  endgenerate

  tcc_state_t s;
  tcc_state_t next_s;
  logic       req;
  logic       acc;
  logic       wr_lane;
  logic [2:0] res;
  logic [2:0] hit;
  logic [7:0] rd_mux;

  assign req = avs_read_i | avs_write_i;
  assign acc = req & s.ack;
  assign wr_lane = acc & avs_write_i & avs_byteenable_i[0];
  assign avs_waitrequest_o = req & ~s.ack;
  assign avs_readdata_o = s.rdata;
  assign event_flag_o = s.flag;
  assign pin_out_o = s.prev;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      logic       en;
      logic       pol;
      tcc_evsel_t ev;
      logic [1:0] isel;
      logic       hit_g;
      logic [4:0] sw;
      assign en   = s.ctrl[g][`TCC_BIT_EN];
      assign pol  = s.ctrl[g][`TCC_BIT_POL];
      assign ev   = tcc_evsel_t'(s.ctrl[g][`TCC_EVSEL_HI:`TCC_EVSEL_LO]);
      assign isel = s.ctrl[g][`TCC_INVSEL_HI:`TCC_INVSEL_LO];
      // polarity applied to the synchronised decision
      assign res[g] = en & (s.sync2[g] ^ pol);
      always_comb begin
        case (ev)
          TCC_EV_RISE: hit_g = en & res[g] & ~s.prev[g];
          TCC_EV_FALL: hit_g = en & ~res[g] & s.prev[g];
          TCC_EV_ANY:  hit_g = en & (res[g] ^ s.prev[g]);
          default:     hit_g = 1'b0;
        endcase
      end
      assign hit[g] = hit_g;
      // one switch of the inverting side closes at a time
      always_comb begin
        sw = 5'h00;
        case (isel)
          TCC_INV_PIN_B:   sw[0] = 1'b1;
          TCC_INV_PIN_C:   sw[1] = 1'b1;
          TCC_INV_BANDGAP: sw[4] = 1'b1;
          TCC_INV_FOURTH: begin
            if (g == 1) begin
              sw[3] = 1'b1;
            end else begin
              sw[2] = 1'b1;
            end
          end
          default: sw = 5'h00;
        endcase
      end
      // enable, non-inverting source and inverting switches as one word
      assign afe_o[g] = {en, s.ctrl[g][`TCC_BIT_NREF], sw};
      assign pin_sel_o[g] = s.ctrl[g][`TCC_BIT_ROUTE];
      assign pin_oe_o[g] = pin_sel_o[g] & pin_dir_i[g];
    end
  endgenerate

  always_comb begin
    case (avs_address_i)
      `TCC_OFF_CTRL0:  rd_mux = s.ctrl[0];
      `TCC_OFF_CTRL1:  rd_mux = s.ctrl[1];
      `TCC_OFF_CTRL2:  rd_mux = s.ctrl[2];
      `TCC_OFF_STATUS: rd_mux = {5'h00, res};
      `TCC_OFF_FLAG:   rd_mux = {5'h00, s.flag};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = cmp_raw_i;
    next_s.sync2 = s.sync1;
    next_s.prev = res;
    next_s.ack = req & ~s.ack;
    if (wr_lane) begin
      case (avs_address_i)
        `TCC_OFF_CTRL0: next_s.ctrl[0] = avs_writedata_i[7:0];
        `TCC_OFF_CTRL1: next_s.ctrl[1] = avs_writedata_i[7:0];
        `TCC_OFF_CTRL2: next_s.ctrl[2] = avs_writedata_i[7:0];
        `TCC_OFF_FLAG:  next_s.flag = avs_writedata_i[2:0];
        default:        next_s.ctrl = s.ctrl;
      endcase
    end
    next_s.flag = next_s.flag | hit;
    if (req & ~s.ack & avs_read_i) begin
      next_s.rdata = {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= {3{`TCC_CTRL_RESET}};
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_STATUS_UPPER: assert property (
    (req && !s.ack && avs_read_i && avs_address_i == `TCC_OFF_STATUS)
      |=> avs_readdata_o[31:3] == 29'h0)
    else $error("status upper bits not zero");
  AST_STATUS_BITS: assert property (
    (req && !s.ack && avs_read_i && avs_address_i == `TCC_OFF_STATUS)
      |=> avs_readdata_o[2:0] == $past(res))
    else $error("status bits do not show results");
  AST_STATUS_RO: assert property (
    (acc && avs_write_i && avs_address_i == `TCC_OFF_STATUS)
      |=> s.ctrl == $past(s.ctrl))
    else $error("status write changed control");
  AST_SYNC: assert property (
    !$past(rst_i, 2) |-> s.sync2 == $past(cmp_raw_i, 2))
    else $error("synchroniser depth wrong");
  AST_POL_PLAIN: assert property (
    (s.ctrl[0][7] && !s.ctrl[0][5]) |-> res[0] == s.sync2[0])
    else $error("non-inverted result wrong");
  AST_POL_INV: assert property (
    (s.ctrl[0][7] && s.ctrl[0][5]) |-> res[0] == !s.sync2[0])
    else $error("inverted result wrong");
  AST_RISE: assert property (
    (s.ctrl[1][7] && s.ctrl[1][4:3] == 2'b01 && res[1] && !s.prev[1])
      |=> s.flag[1])
    else $error("rising edge not flagged");
  AST_NONE: assert property (
    $rose(s.flag[2]) |-> $past(s.ctrl[2][4:3]) != 2'b00 ||
      $past(wr_lane && avs_address_i == `TCC_OFF_FLAG))
    else $error("flag set with events disabled");
  AST_HOLD: assert property (
    (s.flag[0] && !(wr_lane && avs_address_i == `TCC_OFF_FLAG))
      |=> s.flag[0])
    else $error("flag dropped without clear");
  AST_PIN_OE: assert property (
    pin_oe_o[1] == (s.ctrl[1][6] && pin_dir_i[1]))
    else $error("pin enable wrong");
  AST_WAIT: assert property (
    req |-> ##[0:1] !avs_waitrequest_o)
    else $error("waitrequest held too long");

  // register bus
  AST_WAIT_FIRST: assert property (
    (req && !s.ack) |-> avs_waitrequest_o)
    else $error("request answered without a wait state");
  AST_RDATA_HIGH: assert property (
    (req && !s.ack && avs_read_i) |=> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_UNMAPPED: assert property (
    (req && !s.ack && avs_read_i && !(avs_address_i inside {`TCC_OFF_CTRL0,
      `TCC_OFF_CTRL1, `TCC_OFF_CTRL2, `TCC_OFF_STATUS, `TCC_OFF_FLAG}))
      |=> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  AST_FLAG_READ: assert property (
    (req && !s.ack && avs_read_i && avs_address_i == `TCC_OFF_FLAG)
      |=> avs_readdata_o[7:0] == {5'h00, $past(s.flag)})
    else $error("flag readback wrong");

  // channel isolation and control writes
  AST_CTRL_ONLY1: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_CTRL0)
      |=> s.ctrl[2:1] == $past(s.ctrl[2:1]))
    else $error("channel one write reached another channel");
  AST_CTRL_ONLY2: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_CTRL1)
      |=> s.ctrl[2] == $past(s.ctrl[2]) && s.ctrl[0] == $past(s.ctrl[0]))
    else $error("channel two write reached another channel");
  AST_CTRL_ONLY3: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_CTRL2)
      |=> s.ctrl[1:0] == $past(s.ctrl[1:0]))
    else $error("channel three write reached another channel");
  AST_CTRL_WR1: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_CTRL0)
      |=> s.ctrl[0] == $past(avs_writedata_i[7:0]))
    else $error("channel one control write lost");
  AST_CTRL_WR2: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_CTRL1)
      |=> s.ctrl[1] == $past(avs_writedata_i[7:0]))
    else $error("channel two control write lost");
  AST_CTRL_WR3: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_CTRL2)
      |=> s.ctrl[2] == $past(avs_writedata_i[7:0]))
    else $error("channel three control write lost");

  // analog switch control
  AST_OFF1: assert property (
    !s.ctrl[0][`TCC_BIT_EN] |-> !res[0] && !hit[0] && !afe_o[0].en)
    else $error("disabled channel one still active");
  AST_OFF2: assert property (
    !s.ctrl[1][`TCC_BIT_EN] |-> !res[1] && !hit[1] && !afe_o[1].en)
    else $error("disabled channel two still active");
  AST_OFF3: assert property (
    !s.ctrl[2][`TCC_BIT_EN] |-> !res[2] && !hit[2] && !afe_o[2].en)
    else $error("disabled channel three still active");
  AST_FOURTH1: assert property (
    s.ctrl[0][1:0] == 2'b00 |-> afe_o[0].inv_sw == 5'h04)
    else $error("channel one fourth source wrong");
  AST_FOURTH2: assert property (
    s.ctrl[1][1:0] == 2'b00 |-> afe_o[1].inv_sw == 5'h08)
    else $error("channel two fourth source wrong");
  AST_FOURTH3: assert property (
    s.ctrl[2][1:0] == 2'b00 |-> afe_o[2].inv_sw == 5'h04)
    else $error("channel three fourth source wrong");
  AST_ONE_SWITCH: assert property (
    $onehot(afe_o[0].inv_sw) && $onehot(afe_o[1].inv_sw) &&
      $onehot(afe_o[2].inv_sw))
    else $error("inverting switches not one-hot");
  AST_NREF: assert property (
    afe_o[1].ninv_ladder == s.ctrl[1][`TCC_BIT_NREF])
    else $error("non-inverting source wrong");

  // results, events and pins
  AST_POL_PLAIN2: assert property (
    (s.ctrl[1][7] && !s.ctrl[1][5]) |-> res[1] == s.sync2[1])
    else $error("channel two non-inverted result wrong");
  AST_POL_INV2: assert property (
    (s.ctrl[1][7] && s.ctrl[1][5]) |-> res[1] == !s.sync2[1])
    else $error("channel two inverted result wrong");
  AST_POL_PLAIN3: assert property (
    (s.ctrl[2][7] && !s.ctrl[2][5]) |-> res[2] == s.sync2[2])
    else $error("channel three non-inverted result wrong");
  AST_POL_INV3: assert property (
    (s.ctrl[2][7] && s.ctrl[2][5]) |-> res[2] == !s.sync2[2])
    else $error("channel three inverted result wrong");
  AST_FALL: assert property (
    (s.ctrl[0][7] && s.ctrl[0][4:3] == 2'b10 && !res[0] && s.prev[0])
      |=> s.flag[0])
    else $error("falling edge not flagged");
  AST_ANY: assert property (
    (s.ctrl[2][7] && s.ctrl[2][4:3] == 2'b11 && res[2] != s.prev[2])
      |=> s.flag[2])
    else $error("change not flagged");
  AST_CLEAR: assert property (
    (wr_lane && avs_address_i == `TCC_OFF_FLAG)
      |=> s.flag == ($past(avs_writedata_i[2:0]) | $past(hit)))
    else $error("flag write not applied");
  AST_PIN_OUT: assert property (
    !$past(rst_i) |-> pin_out_o == $past(res))
    else $error("pin output does not follow result");
  AST_ROUTE: assert property (
    pin_sel_o == {s.ctrl[2][6], s.ctrl[1][6], s.ctrl[0][6]})
    else $error("pin route wrong");
  AST_PIN_OE_ALL: assert property (
    pin_oe_o == (pin_sel_o & pin_dir_i))
    else $error("pin enables wrong");

  COV_RISE: cover property (s.ctrl[0][4:3] == 2'b01 && $rose(s.flag[0]));
  COV_FALL: cover property (s.ctrl[1][4:3] == 2'b10 && $rose(s.flag[1]));
  COV_STAT: cover property (acc && avs_read_i &&
    avs_address_i == `TCC_OFF_STATUS);
  COV_PIN: cover property (pin_oe_o[2] && pin_out_o[2]);
  COV_ANY: cover property (s.ctrl[2][4:3] == 2'b11 && $rose(s.flag[2]));

endmodule

//--- include/tcc_pkg.sv
// types of the comparator control block
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_EV_NONE = 2'b00,
    TCC_EV_RISE = 2'b01,
    TCC_EV_FALL = 2'b10,
    TCC_EV_ANY  = 2'b11
  } tcc_evsel_t;
  typedef enum logic [1:0] {
    TCC_INV_FOURTH  = 2'b00,
    TCC_INV_PIN_C   = 2'b01,
    TCC_INV_PIN_B   = 2'b10,
    TCC_INV_BANDGAP = 2'b11
  } tcc_invsel_t;
  // analog switch control for one channel; inv_sw is one-hot
  // {bandgap, second_channel_pin_d, second_channel_pin_b, pin_c, pin_b}
  typedef struct packed {
    logic       en;
    logic       ninv_ladder;
    logic [4:0] inv_sw;
  } tcc_afe_t;
  typedef struct packed {
    logic [2:0][7:0] ctrl;
    logic [2:0]      sync1;
    logic [2:0]      sync2;
    logic [2:0]      prev;
    logic [2:0]      flag;
    logic            ack;
    logic [31:0]     rdata;
  } tcc_state_t;
endpackage

//--- include/tcc_regs.svh
// register offsets, field positions and reset values of the comparator block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_OFF_CTRL0   8'h00
`define TCC_OFF_CTRL1   8'h04
`define TCC_OFF_CTRL2   8'h08
`define TCC_OFF_STATUS  8'h0C
`define TCC_OFF_FLAG    8'h10
`define TCC_CTRL_RESET  8'h1F
`define TCC_BIT_EN      7
`define TCC_BIT_ROUTE   6
`define TCC_BIT_POL     5
`define TCC_EVSEL_HI    4
`define TCC_EVSEL_LO    3
`define TCC_BIT_NREF    2
`define TCC_INVSEL_HI   1
`define TCC_INVSEL_LO   0
`define TCC_NUM_CH      3
`endif

//--- verif/tcc_afe_model.sv
// model of three analog comparators fed by test voltages
`timescale 1ns/1ps
module tcc_afe_model
  import tcc_pkg::*;
(
  // clock
  input  wire logic      clk_i,
  // switches; volts a 0-2, b 3-5, c 6-8, d 9, ladder 10, gap 11
  input  tcc_afe_t [2:0] afe_i,
  input  int             v_i [12],
  // raw decisions
  output logic [2:0]     raw_o
);
  logic tog = 1'b0;
  always @(posedge clk_i) tog <= ~tog;
  always_comb begin
    int n;
    n = 0;
    for (int i = 0; i < 3; i++) begin
      n = afe_i[i].inv_sw[0] ? v_i[3+i] : afe_i[i].inv_sw[1] ? v_i[6+i]
        : afe_i[i].inv_sw[2] ? v_i[4] : afe_i[i].inv_sw[3] ? v_i[9]
        : v_i[11];
      raw_o[i] = !afe_i[i].en ? tog
        : (afe_i[i].ninv_ladder ? v_i[10] : v_i[i]) > n;
    end
  end
endmodule

//--- verif/triple_comparator_control_bench.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`include "tcc_regs.svh"
module triple_comparator_control_bench
  import tcc_pkg::*;
;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           rd = 1'b0;
  logic           wr = 1'b0;
  logic [7:0]     adr = 8'h00;
  logic [31:0]    wdat = 32'h0;
  logic [2:0]     dir = 3'h0;
  logic [31:0]    rdat;
  logic           wreq;
  logic [2:0]     raw, psel, pout, poe, flg;
  tcc_afe_t [2:0] afe;
  int             v [12];
  int             failures = 0;
  int             check_count = 0;
  int             cyc = 0;
  logic [31:0]    expq [$];
  always #10 clk_i = ~clk_i;
  tcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .cmp_raw_i(raw), .afe_o(afe),
    .pin_dir_i(dir), .pin_sel_o(psel), .pin_out_o(pout),
    .pin_oe_o(poe), .event_flag_o(flg));
  tcc_afe_model afe_m (.clk_i(clk_i), .afe_i(afe), .v_i(v), .raw_o(raw));
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t pins %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  function automatic logic [7:0] ctl(int c);
    return `TCC_OFF_CTRL0 + 8'(4 * c);
  endfunction
  function automatic logic model(int c, logic [2:0] s);
    int n;
    n = s[1:0] == 2'b00 ? v[c == 1 ? 9 : 4] : s[1:0] == 2'b01 ? v[6 + c]
      : s[1:0] == 2'b10 ? v[3 + c] : v[11];
    return (s[2] ? v[10] : v[c]) > n;
  endfunction
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rd === 1'b1 && wreq === 1'b0) begin
      cmp(rdat, expq.pop_front());
    end
    if (cyc == 8000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    logic [7:0] r [3];
    logic       p;
    logic       q;
    logic       e;
    logic [2:0] m;
    logic [2:0] x;
    void'($urandom(32'h609CC59E));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 3; c++) rdx(ctl(c), `TCC_CTRL_RESET);
    rdx(8'h14, 8'h00);
    bus(1'b1, `TCC_OFF_STATUS, 8'hFF);
    rdx(`TCC_OFF_STATUS, 8'h00);
    for (int c = 0; c < 3; c++) begin
      r[c] = 8'($urandom);
      bus(1'b1, ctl(c), r[c]);
    end
    for (int c = 0; c < 3; c++) rdx(ctl(c), r[c]);
    for (int c = 0; c < 3; c++) bus(1'b1, ctl(c), 8'h00);
    bus(1'b1, `TCC_OFF_FLAG, 8'h00);
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 8; k++) begin
        for (int j = 0; j < 12; j++) v[j] <= $urandom_range(99);
        p = 1'($urandom);
        q = 1'($urandom);
        bus(1'b1, ctl(c), {1'b1, q, p, 2'b00, 3'(k)});
        dir <= 3'($urandom);
        repeat (4) @(posedge clk_i);
        e = model(c, 3'(k)) ^ p;
        m = 3'(q) << c;
        x = 3'(e) << c;
        cmp_pin({psel, poe, pout, flg}, {m, m & dir, x, 3'h0});
        rdx(`TCC_OFF_STATUS, {5'h00, 3'(e) << c});
      end
      bus(1'b1, ctl(c), 8'h00);
    end
    for (int c = 0; c < 3; c++) begin
      for (int k = 1; k < 4; k++) begin
        v[c] <= 20;
        v[3 + c] <= 50;
        bus(1'b1, ctl(c), {3'b100, 2'(k), 3'b010});
        repeat (4) @(posedge clk_i);
        bus(1'b1, `TCC_OFF_FLAG, 8'h00);
        v[c] <= 80;
        repeat (4) @(posedge clk_i);
        rdx(`TCC_OFF_FLAG, {5'h00, 3'(k % 2) << c});
        v[c] <= 20;
        repeat (4) @(posedge clk_i);
        rdx(`TCC_OFF_FLAG, {5'h00, 3'h1 << c});
      end
      bus(1'b1, ctl(c), 8'h00);
    end
    bus(1'b1, `TCC_OFF_FLAG, 8'h05);
    rdx(`TCC_OFF_FLAG, 8'h05);
    end_sim();
  end
endmodule
